// ==== verilog/afecfg_params.svh ====
// Purpose: Constants of the AFE configuration bank and its bus master
// Assumes: 100 MHz system clock, standard-mode two-wire bus
// Notes:   Definitions only
`ifndef AFECFG_PARAMS_SVH
`define AFECFG_PARAMS_SVH

// Register pointers
`define AFECFG_PTR_READY    8'h00
`define AFECFG_PTR_PROTECT  8'h01
`define AFECFG_PTR_GAIN     8'h10
`define AFECFG_PTR_REF      8'h11
`define AFECFG_PTR_MODE     8'h12

// Power-on defaults
`define AFECFG_RST_PROTECT  8'h01
`define AFECFG_RST_GAIN     8'h03
`define AFECFG_RST_REF      8'h20
`define AFECFG_RST_MODE     8'h00

// Field positions
`define AFECFG_LOCK_BIT     0
`define AFECFG_GAIN_HI     4
`define AFECFG_GAIN_LO     2
`define AFECFG_SRC_BIT     7
`define AFECFG_ZERO_HI     6
`define AFECFG_ZERO_LO     5
`define AFECFG_DIAG_HI     3
`define AFECFG_SHORT_BIT   7
`define AFECFG_MODE_HI     2

// Operating mode codes
`define AFECFG_MODE_SLEEP   3'h0
`define AFECFG_MODE_STANDBY 3'h2
`define AFECFG_MODE_AMPERO  3'h3

// Fixed slave address 1001 000
`define AFECFG_SLAVE_ADDR   7'h48

// Power-on initialisation length (plain default, cycles)
`define AFECFG_INIT_CYCLES  16

// Bus timing: quarter of an SCL period in system cycles
`define AFECFG_CLK_HZ       100000000
`define AFECFG_SCL_HZ       100000
`define AFECFG_QUARTER      (`AFECFG_CLK_HZ / (4 * `AFECFG_SCL_HZ))

// Host register byte addresses and command bit positions
`define AFECFG_WB_CMD       4'h0
`define AFECFG_WB_STAT      4'h4
`define AFECFG_GO_BIT       31
`define AFECFG_RD_BIT       16

`endif

// ==== verilog/afecfg_pkg.sv ====
// Purpose: Types shared by both ends of the AFE configuration link
// Assumes: Constants come from afecfg_params.svh
// Notes:   State codes are one-hot
`include "afecfg_params.svh"
package afecfg_pkg;

  // Device-side bus states
  typedef enum logic [4:0] {
    DS_IDLE  = 5'h01,
    DS_RX    = 5'h02,
    DS_ACK   = 5'h04,
    DS_TX    = 5'h08,
    DS_TXACK = 5'h10
  } afecfg_dst_t;

  // Host-side sequencer states
  typedef enum logic [4:0] {
    HS_IDLE  = 5'h01,
    HS_SEL   = 5'h02,
    HS_START = 5'h04,
    HS_BYTE  = 5'h08,
    HS_STOP  = 5'h10
  } afecfg_hst_t;

  // Device state
  typedef struct packed {
    afecfg_dst_t st;
    logic [15:0] init_cnt;
    logic        ready;
    logic        scl_prev;
    logic        sda_prev;
    logic [7:0]  shr;
    logic [3:0]  cnt;
    logic [1:0]  byte_idx;
    logic        rw;
    logic        sda_low;
    logic [7:0]  ptr;
    logic [7:0]  protect;
    logic [7:0]  gain;
    logic [7:0]  refc;
    logic [7:0]  mode;
    logic        ctl_amp_en;
    logic        tia_en;
  } afecfg_dev_t;

  // Host state
  typedef struct packed {
    afecfg_hst_t st;
    logic [15:0] qcnt;
    logic [1:0]  phase;
    logic [3:0]  bit_cnt;
    logic [2:0]  step;
    logic [8:0]  shr;
    logic        scl_low;
    logic        sda_low;
    logic        sel_n;
    logic        busy;
    logic        nack;
    logic [7:0]  rdata;
    logic [7:0]  wdata;
    logic [7:0]  ptr;
    logic        rd;
    logic        ack;
    logic [31:0] dat;
  } afecfg_host_t;

endpackage : afecfg_pkg

// ==== verilog/afecfg_link_if.sv ====
// Purpose: Two-wire link plus module select between host and device
// Assumes: Open-drain lines with pull-ups, modelled here
// Notes:   A line is low when any enabled driver outputs low
`timescale 1ns/100ps
interface afecfg_link_if;
  logic scl_host_o;      // Clock line output value
  logic scl_host_oe;     // Host drives clock line
  logic sda_host_o;      // Host data output value
  logic sda_host_oe;     // Host drives data line
  logic sda_dev_o;       // Device data output value
  logic sda_dev_oe;      // Device drives data line
  logic module_select_n; // Active-low module select
  logic scl;             // Resolved clock line
  logic sda;             // Resolved data line

  // Pull-up resolution of the open-drain wires
  assign scl = ~(scl_host_oe & ~scl_host_o);
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe,
                output module_select_n, input scl, sda);
  modport dev  (output sda_dev_o, sda_dev_oe,
                input scl, sda, module_select_n);
endinterface : afecfg_link_if

// ==== verilog/afecfg_dev.sv ====
// Purpose: Configuration register bank with its two-wire slave port
// Assumes: SCL and SDA are synchronous to CLK_SYS
// Notes:   Outputs are static control codes to the analog section
`timescale 1ns/100ps
`include "afecfg_params.svh"

// Contract
// - Host writes zero to reserved bits
// - Not ready until init; then bus accepted
// - Lock bit gates gain and reference writes
// - Host clears lock before gain/reference change
// - Gain field selects feedback resistance
// - Reference bit selects internal or external source
// - External source scales internal zero
// - Zero field selects 20, 50, 67 percent
// - Diagnostic field sets step fraction
// - Bit seven enables shorting switch
// - Mode field selects sleep, standby, amperometric
// - Amperometric mode powers both amplifiers
// - Host selects external gain code when fitted
// - Bus ignored while module select high
// - Only the selected device acknowledges
// - Host selects one device at a time
// - Host holds select low whole transaction
// - Acknowledge only fixed address 1001000
// - Write is address, pointer, data, stop
// - Read sets pointer, restarts, returns byte
module afecfg_dev #(
  parameter int INIT_CYCLES = `AFECFG_INIT_CYCLES // Power-on init length
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // Link to host
  afecfg_link_if.dev      LINK,
  // Analog control codes
  output logic [2:0]      FEEDBACK_GAIN_SELECT,
  output logic            REF_SOURCE_EXTERNAL,
  output logic [1:0]      INTERNAL_ZERO_SELECT,
  output logic [3:0]      DIAGNOSTIC_STEP,
  output logic            SHORTING_SWITCH_ENABLE,
  output logic [2:0]      OPERATING_MODE_SELECT,
  output logic            CONTROL_AMPLIFIER_EN,
  output logic            TRANSIMPEDANCE_AMPLIFIER_EN,
  output logic            READY
);

  afecfg_pkg::afecfg_dev_t q_q; // Registered state
  afecfg_pkg::afecfg_dev_t q_d; // Next state

  logic       scl_rise;  // Clock line rising
  logic       scl_fall;  // Clock line falling
  logic       start_cnd; // Start or repeated start
  logic       stop_cnd;  // Stop condition
  logic [7:0] rd_byte;   // Register selected by pointer
  logic       locked;    // Gain and reference protected

  // Edge and condition detection against last sample
  assign scl_rise  = LINK.scl & ~q_q.scl_prev;
  assign scl_fall  = ~LINK.scl & q_q.scl_prev;
  assign start_cnd = LINK.scl & q_q.scl_prev & q_q.sda_prev & ~LINK.sda;
  assign stop_cnd  = LINK.scl & q_q.scl_prev & ~q_q.sda_prev & LINK.sda;
  assign locked    = q_q.protect[`AFECFG_LOCK_BIT];

  // Readback mux; unmapped pointers read zero
  always_comb begin
    case (q_q.ptr)
      `AFECFG_PTR_READY:   rd_byte = {7'h00, q_q.ready};
      `AFECFG_PTR_PROTECT: rd_byte = q_q.protect;
      `AFECFG_PTR_GAIN:    rd_byte = q_q.gain;
      `AFECFG_PTR_REF:     rd_byte = q_q.refc;
      `AFECFG_PTR_MODE:    rd_byte = q_q.mode;
      default:             rd_byte = 8'h00;
    endcase
  end

  // Next-state logic
  always_comb begin
    q_d          = q_q;
    q_d.scl_prev = LINK.scl;
    q_d.sda_prev = LINK.sda;

    // Power-on initialisation count
    if (!q_q.ready) begin
      if (q_q.init_cnt == 16'(INIT_CYCLES - 1)) begin
        q_d.ready = 1'b1;
      end else begin
        q_d.init_cnt = q_q.init_cnt + 16'h0001;
      end
    end

    if (LINK.module_select_n) begin
      // Deselected: port dormant, line released
      q_d.st      = afecfg_pkg::DS_IDLE;
      q_d.sda_low = 1'b0;
    end else if (start_cnd) begin
      // Start restarts byte framing
      q_d.st       = afecfg_pkg::DS_RX;
      q_d.cnt      = 4'h0;
      q_d.byte_idx = 2'h0;
      q_d.sda_low  = 1'b0;
    end else if (stop_cnd) begin
      q_d.st      = afecfg_pkg::DS_IDLE;
      q_d.sda_low = 1'b0;
    end else begin
      case (q_q.st)
        afecfg_pkg::DS_IDLE: begin
          q_d.sda_low = 1'b0;
        end
        afecfg_pkg::DS_RX: begin
          // Shift data on rising clock
          if (scl_rise && q_q.cnt < 4'h8) begin
            q_d.shr = {q_q.shr[6:0], LINK.sda};
            q_d.cnt = q_q.cnt + 4'h1;
          end else if (scl_fall && q_q.cnt == 4'h8) begin
            // Whole byte in: decide acknowledge
            q_d.st      = afecfg_pkg::DS_ACK;
            q_d.sda_low = 1'b1;
            case (q_q.byte_idx)
              2'h0: begin
                q_d.rw = q_q.shr[0];
                // Address match and ready, else not acknowledged
                if (q_q.shr[7:1] != `AFECFG_SLAVE_ADDR || !q_q.ready) begin
                  q_d.st      = afecfg_pkg::DS_IDLE;
                  q_d.sda_low = 1'b0;
                end
              end
              2'h1: begin
                q_d.ptr = q_q.shr;
              end
              2'h2: begin
                // Data byte write with protection
                case (q_q.ptr)
                  `AFECFG_PTR_PROTECT: q_d.protect = q_q.shr;
                  `AFECFG_PTR_GAIN: begin
                    if (!locked) begin
                      q_d.gain = q_q.shr;
                    end
                  end
                  `AFECFG_PTR_REF: begin
                    if (!locked) begin
                      q_d.refc = q_q.shr;
                    end
                  end
                  `AFECFG_PTR_MODE: begin
                    q_d.mode = q_q.shr;
                    // Amplifier power follows mode
                    case (q_q.shr[`AFECFG_MODE_HI:0])
                      `AFECFG_MODE_AMPERO: begin
                        q_d.ctl_amp_en = 1'b1;
                        q_d.tia_en     = 1'b1;
                      end
                      `AFECFG_MODE_STANDBY: begin
                        q_d.ctl_amp_en = 1'b1;
                        q_d.tia_en     = 1'b0;
                      end
                      default: begin
                        q_d.ctl_amp_en = 1'b0;
                        q_d.tia_en     = 1'b0;
                      end
                    endcase
                  end
                  default: begin
                    q_d.ptr = q_q.ptr; // Read-only or unmapped
                  end
                endcase
              end
              default: begin
                q_d.ptr = q_q.ptr; // Extra bytes acked, dropped
              end
            endcase
          end
        end
        afecfg_pkg::DS_ACK: begin
          // Release ack after the ninth clock
          if (scl_fall) begin
            q_d.cnt = 4'h0;
            if (q_q.rw) begin
              // Read: first data bit goes out now
              q_d.st      = afecfg_pkg::DS_TX;
              q_d.shr     = {rd_byte[6:0], 1'b0};
              q_d.sda_low = ~rd_byte[7];
              q_d.cnt     = 4'h1;
            end else begin
              q_d.st       = afecfg_pkg::DS_RX;
              q_d.sda_low  = 1'b0;
              q_d.byte_idx = (q_q.byte_idx == 2'h3) ? 2'h3
                                                    : q_q.byte_idx + 2'h1;
            end
          end
        end
        afecfg_pkg::DS_TX: begin
          // Shift data out on falling clock
          if (scl_fall) begin
            if (q_q.cnt == 4'h8) begin
              q_d.st      = afecfg_pkg::DS_TXACK;
              q_d.sda_low = 1'b0;
            end else begin
              q_d.sda_low = ~q_q.shr[7];
              q_d.shr     = {q_q.shr[6:0], 1'b0};
              q_d.cnt     = q_q.cnt + 4'h1;
            end
          end
        end
        afecfg_pkg::DS_TXACK: begin
          // Master ack repeats the byte, nack ends the read
          if (scl_rise) begin
            q_d.st = LINK.sda ? afecfg_pkg::DS_IDLE : afecfg_pkg::DS_ACK;
          end
        end
        default: begin
          q_d.st      = afecfg_pkg::DS_IDLE;
          q_d.sda_low = 1'b0;
        end
      endcase
    end
  end

  // State register; defaults at power-on
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      q_q            <= '0;
      q_q.st         <= afecfg_pkg::DS_IDLE;
      q_q.scl_prev   <= 1'b1;
      q_q.sda_prev   <= 1'b1;
      q_q.protect    <= `AFECFG_RST_PROTECT;
      q_q.gain       <= `AFECFG_RST_GAIN;
      q_q.refc       <= `AFECFG_RST_REF;
      q_q.mode       <= `AFECFG_RST_MODE;
    end else begin
      q_q <= q_d;
    end
  end

  // Analog controls from register bits; amplifier enables from flops set on mode write
  assign FEEDBACK_GAIN_SELECT   = q_q.gain[`AFECFG_GAIN_HI:`AFECFG_GAIN_LO];
  assign REF_SOURCE_EXTERNAL    = q_q.refc[`AFECFG_SRC_BIT];
  assign INTERNAL_ZERO_SELECT   = q_q.refc[`AFECFG_ZERO_HI:`AFECFG_ZERO_LO];
  assign DIAGNOSTIC_STEP        = q_q.refc[`AFECFG_DIAG_HI:0];
  assign SHORTING_SWITCH_ENABLE = q_q.mode[`AFECFG_SHORT_BIT];
  assign OPERATING_MODE_SELECT  = q_q.mode[`AFECFG_MODE_HI:0];
  assign CONTROL_AMPLIFIER_EN   = q_q.ctl_amp_en;
  assign TRANSIMPEDANCE_AMPLIFIER_EN = q_q.tia_en;
  assign READY                  = q_q.ready;

  // Open-drain data: only ever pulls low
  assign LINK.sda_dev_o  = 1'b0;
  assign LINK.sda_dev_oe = q_q.sda_low;

endmodule : afecfg_dev

// ==== verilog/afecfg_host.sv ====
// Purpose: Wishbone-commanded two-wire master for the configuration bank
// Assumes: Single device on the link; SCL/SDA synchronous to CLK_SYS
// Notes:   One write or one read per command; busy while it runs
`timescale 1ns/100ps
`include "afecfg_params.svh"
module afecfg_host #(
  parameter int QUARTER = `AFECFG_QUARTER // Cycles per SCL quarter
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Wishbone classic slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [3:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Link to device
  afecfg_link_if.host      LINK
);

  afecfg_pkg::afecfg_host_t q_q; // Registered state
  afecfg_pkg::afecfg_host_t q_d; // Next state

  logic        tick;  // End of a quarter period
  logic        req;   // New bus cycle
  logic [31:0] wmask; // Byte-lane write mask

  assign tick = (q_q.qcnt == 16'(QUARTER - 1));
  assign req  = WB_CYC_I & WB_STB_I & ~q_q.ack;

  // Byte to send for a given step
  function automatic logic [7:0] step_byte(input logic [2:0] s,
                                           input logic [7:0] p,
                                           input logic [7:0] w);
    case (s)
      3'h0:    step_byte = {`AFECFG_SLAVE_ADDR, 1'b0};
      3'h1:    step_byte = p;
      3'h2:    step_byte = w;
      3'h3:    step_byte = {`AFECFG_SLAVE_ADDR, 1'b1};
      default: step_byte = 8'hff; // Released: read byte, then nack
    endcase
  endfunction : step_byte

  // Lane mask from byte selects
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign wmask[i*8 +: 8] = {8{WB_SEL_I[i]}};
  end

  // Next-state logic
  always_comb begin
    q_d     = q_q;
    q_d.ack = req;
    // Register access, one wait state
    if (req) begin
      q_d.dat = 32'h0000_0000;
      if (WB_ADR_I == `AFECFG_WB_STAT) begin
        q_d.dat = {16'h0000, q_q.rdata, 6'h00, q_q.nack, q_q.busy};
      end else if (WB_ADR_I == `AFECFG_WB_CMD) begin
        q_d.dat = {15'h0000, q_q.rd, q_q.ptr, q_q.wdata};
        if (WB_WE_I && !q_q.busy) begin
          if (WB_SEL_I[0]) q_d.wdata = WB_DAT_I[7:0];
          if (WB_SEL_I[1]) q_d.ptr   = WB_DAT_I[15:8];
          if (WB_SEL_I[2]) q_d.rd    = WB_DAT_I[`AFECFG_RD_BIT];
          if ((WB_DAT_I & wmask) >> `AFECFG_GO_BIT != 32'h0) begin
            q_d.busy  = 1'b1;
            q_d.nack  = 1'b0;
            q_d.step  = 3'h0;
            q_d.sel_n = 1'b0;
            q_d.qcnt  = 16'h0000;
            q_d.st    = afecfg_pkg::HS_SEL;
          end
        end
      end
    end

    // Bit sequencer, quarter-period paced
    if (q_q.st != afecfg_pkg::HS_IDLE) begin
      q_d.qcnt = tick ? 16'h0000 : q_q.qcnt + 16'h0001;
    end
    if (tick) begin
      q_d.phase = q_q.phase + 2'h1;
      case (q_q.st)
        afecfg_pkg::HS_SEL: begin
          q_d.st    = afecfg_pkg::HS_START;
          q_d.phase = 2'h0;
        end
        afecfg_pkg::HS_START: begin
          // Data falls while clock high
          case (q_q.phase)
            2'h0:    q_d.scl_low = 1'b0;
            2'h1:    q_d.sda_low = 1'b1;
            2'h2:    q_d.scl_low = 1'b1;
            default: begin
              q_d.st      = afecfg_pkg::HS_BYTE;
              q_d.bit_cnt = 4'h0;
              q_d.shr     = {step_byte(q_q.step, q_q.ptr, q_q.wdata), 1'b1};
            end
          endcase
        end
        afecfg_pkg::HS_BYTE: begin
          // Data moves a quarter before the clock rises, never with it
          case (q_q.phase)
            2'h0: q_d.sda_low = ~q_q.shr[8];
            2'h1: q_d.scl_low = 1'b0;
            2'h2: q_d.shr = {q_q.shr[7:0], LINK.sda};
            default: begin
              q_d.scl_low = 1'b1;
              q_d.bit_cnt = q_q.bit_cnt + 4'h1;
              if (q_q.bit_cnt == 4'h8) begin
                q_d.bit_cnt = 4'h0;
                q_d.sda_low = 1'b0;
                q_d.step    = q_q.step + 3'h1;
                q_d.shr     = {step_byte(q_q.step + 3'h1, q_q.ptr,
                                         q_q.wdata), 1'b1};
                if (q_q.step == 3'h4) begin
                  q_d.rdata = q_q.shr[8:1];
                  q_d.st    = afecfg_pkg::HS_STOP;
                end else if (q_q.shr[0]) begin
                  q_d.nack  = 1'b1;
                  q_d.st    = afecfg_pkg::HS_STOP;
                end else if (q_q.step == 3'h2) begin
                  q_d.st    = afecfg_pkg::HS_STOP;
                end else if (q_q.step == 3'h1 && q_q.rd) begin
                  q_d.step  = 3'h3; // Repeated start
                  q_d.st    = afecfg_pkg::HS_START;
                end
              end
            end
          endcase
        end
        afecfg_pkg::HS_STOP: begin
          // Data rises while clock high
          case (q_q.phase)
            2'h0: q_d.sda_low = 1'b1;
            2'h1: q_d.scl_low = 1'b0;
            2'h2: q_d.sda_low = 1'b0;
            default: begin
              q_d.sel_n = 1'b1;
              q_d.busy  = 1'b0;
              q_d.st    = afecfg_pkg::HS_IDLE;
            end
          endcase
        end
        default: q_d.phase = 2'h0;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      q_q       <= '0;
      q_q.st    <= afecfg_pkg::HS_IDLE;
      q_q.sel_n <= 1'b1;
    end else begin
      q_q <= q_d;
    end
  end

  // Outputs from the state flops
  assign WB_DAT_O             = q_q.dat;
  assign WB_ACK_O             = q_q.ack;
  assign LINK.scl_host_o      = 1'b0;
  assign LINK.scl_host_oe     = q_q.scl_low;
  assign LINK.sda_host_o      = 1'b0;
  assign LINK.sda_host_oe     = q_q.sda_low;
  assign LINK.module_select_n = q_q.sel_n;

endmodule : afecfg_host

// ==== testbench/afecfg_link_properties.sv ====
// Purpose: Wire-level properties of the configuration link
// Assumes: One clock domain; bench quarter of 8 cycles
// Notes:   Sees only the interface signals, no bind
`timescale 1ns/100ps
module afecfg_link_properties (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Link wires
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic module_select_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // Frame edges: data moves while the clock line is high
  sequence start_s; $fell(sda) && scl; endsequence
  sequence stop_s; $rose(sda) && scl; endsequence

  desel_quiet_a: assert property (module_select_n |-> !sda_dev_oe)
    else $error("device drives data while deselected");
  dev_low_a: assert property (sda_dev_oe |-> !sda_dev_o)
    else $error("device drives data high");
  dev_edge_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data moved while clock high");
  host_skew_a: assert property (
    $changed(sda_host_oe) |-> $stable(scl_host_oe))
    else $error("host data moved with a clock edge");
  frame_start_a: assert property (start_s |-> !module_select_n)
    else $error("start outside select");
  frame_stop_a: assert property (stop_s |-> !module_select_n)
    else $error("stop outside select");
  scl_frame_a: assert property (scl_host_oe |-> !module_select_n)
    else $error("clock driven while deselected");
  ack_hold_a: assert property ($rose(sda_dev_oe) |-> sda_dev_oe[*8])
    else $error("device low bit too short");
  sel_start_a: assert property ($fell(module_select_n) |-> ##[1:64] start_s)
    else $error("no start after select");
endmodule : afecfg_link_properties

// ==== testbench/tb.sv ====
// Purpose: Random and corner tests of host and device joined by the link
// Assumes: QUARTER 8, INIT_CYCLES 400 so an early command is refused
// Notes:   Registers reached only through the host's Wishbone port
`timescale 1ns/100ps
`include "afecfg_params.svh"
module tb;
  logic        clk, nrst, cyc, stb, we;   // Clock, reset, bus strobes
  logic [3:0]  adr, sel;                  // Bus address and lanes
  logic [31:0] wdat, rdat, q;             // Bus data and last status
  logic        ack, rsrc, shrt, camp, tamp, rdy;
  logic [2:0]  gsel, msel;
  logic [1:0]  zsel;
  logic [3:0]  diag;
  logic [7:0]  v, rv;                     // Value under test, last ref
  int          n_fail, n_tests, ncyc, seed;
  afecfg_link_if afecfg_link_if_inst ();
  afecfg_dev #(.INIT_CYCLES(400)) afecfg_dev_inst (.CLK_SYS(clk),
    .NRST(nrst), .LINK(afecfg_link_if_inst), .FEEDBACK_GAIN_SELECT(gsel),
    .REF_SOURCE_EXTERNAL(rsrc), .INTERNAL_ZERO_SELECT(zsel),
    .DIAGNOSTIC_STEP(diag), .SHORTING_SWITCH_ENABLE(shrt),
    .OPERATING_MODE_SELECT(msel), .CONTROL_AMPLIFIER_EN(camp),
    .TRANSIMPEDANCE_AMPLIFIER_EN(tamp), .READY(rdy));
  afecfg_host #(.QUARTER(8)) afecfg_host_inst (.CLK_SYS(clk), .NRST(nrst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .LINK(afecfg_link_if_inst));
  afecfg_link_properties afecfg_link_properties_inst (.CLK_SYS(clk),
    .NRST(nrst), .scl_host_o(afecfg_link_if_inst.scl_host_o),
    .scl_host_oe(afecfg_link_if_inst.scl_host_oe),
    .sda_host_o(afecfg_link_if_inst.sda_host_o),
    .sda_host_oe(afecfg_link_if_inst.sda_host_oe),
    .sda_dev_o(afecfg_link_if_inst.sda_dev_o),
    .sda_dev_oe(afecfg_link_if_inst.sda_dev_oe),
    .module_select_n(afecfg_link_if_inst.module_select_n),
    .scl(afecfg_link_if_inst.scl), .sda(afecfg_link_if_inst.sda));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard: a run is about 55k cycles
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 95000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    // No timeout of its own; the hang guard ends a stuck wait
    do @(posedge clk);
    while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask : wb

  // One link command, then poll until the host is idle
  task automatic xfer(input logic rd, input logic [7:0] p, d);
    wb(1'b1, `AFECFG_WB_CMD, {1'b1, 14'h0, rd, p, d}, q);
    do wb(1'b0, `AFECFG_WB_STAT, 32'h0, q);
    while (q[0] !== 1'b0);
  endtask : xfer

  // Write then read back the same pointer
  task automatic wr_rd(input string nm, input logic [7:0] p, d, exp);
    xfer(1'b0, p, d);
    xfer(1'b1, p, 8'h00);
    chk(nm, {24'h0, q[15:8]}, {24'h0, exp});
  endtask : wr_rd

  // Amplifier enables implied by a mode code
  function automatic logic [1:0] amps(input logic [2:0] m);
    return (m == `AFECFG_MODE_AMPERO) ? 2'b11 :
           (m == `AFECFG_MODE_STANDBY) ? 2'b10 : 2'b00;
  endfunction : amps

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  initial begin
    logic [7:0] ptrs [5];
    logic [7:0] dflt [5];
    ptrs = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12};
    dflt = '{8'h01, 8'h01, 8'h03, 8'h20, 8'h00};
    {nrst, cyc, stb, we, adr, sel, wdat} = '0;
    seed = $urandom(32'h6fc6);
    repeat (10) @(posedge clk);
    chk("reset outputs", {gsel, rsrc, zsel, diag, shrt, msel, camp, tamp, rdy},
        {3'h0, 1'b0, 2'h1, 4'h0, 1'b0, 3'h0, 3'h0});
    nrst <= 1'b1;
    xfer(1'b0, `AFECFG_PTR_MODE, 8'h03);
    chk("early nack", q[1], 1'b1);
    chk("early mode", msel, 3'h0);
    for (int n = 0; n < 500 && rdy !== 1'b1; n++) @(posedge clk);
    for (int i = 0; i < 5; i++) wr_rd("defaults", ptrs[i], dflt[i], dflt[i]);
    $display("test defaults done");
    wr_rd("locked gain", `AFECFG_PTR_GAIN, 8'h1c, 8'h03);
    chk("locked gain out", gsel, 3'h0);
    wr_rd("unlock", `AFECFG_PTR_PROTECT, 8'h00, 8'h00);
    for (int g = 0; g < 8; g++) begin
      v = {3'h0, g[2:0], 2'h0};
      wr_rd("gain", `AFECFG_PTR_GAIN, v, v);
      chk("gain out", gsel, g[2:0]);
    end
    $display("test gain done");
    for (int z = 0; z < 3; z++) begin
      v = {1'($urandom), z[1:0], 1'b0, 3'h0, 1'($urandom)};
      rv = v;
      wr_rd("ref", `AFECFG_PTR_REF, v, v);
      chk("ref out", {rsrc, zsel, diag}, {v[7:5], v[3:0]});
    end
    $display("test reference done");
    for (int m = 0; m < 4; m++) begin
      v = {1'($urandom), 4'h0, (m == 0) ? 3'h0 : 3'(m + 1)};
      wr_rd("mode", `AFECFG_PTR_MODE, v, v);
      chk("mode out", {shrt, msel}, {v[7], v[2:0]});
      chk("amps", {camp, tamp}, amps(v[2:0]));
    end
    $display("test mode done");
    wr_rd("relock", `AFECFG_PTR_PROTECT, 8'h01, 8'h01);
    wr_rd("locked ref", `AFECFG_PTR_REF, ~rv & 8'hef, rv);
    chk("locked ref out", {rsrc, zsel, diag}, {rv[7:5], rv[3:0]});
    wr_rd("status ro", `AFECFG_PTR_READY, 8'h00, 8'h01);
    wb(1'b0, 4'h8, 32'h0, q);
    chk("unmapped", q, 32'h0);
    $display("test protection done");
    end_of_test();
  end
endmodule : tb
